// ---- rtl/ncsm_pkg.sv ----
// Package with address map, command codes and reset values for the configuration loader.
package ncsm_pkg;
  // ==========================================================================
  // Address map of the non-volatile extras.
  localparam logic [15:0] SIG_ADDR0       = 16'hfc30;
  localparam logic [15:0] SIG_ADDR1       = 16'hfc31;
  localparam logic [15:0] SIG_ADDR2       = 16'hfc60;
  localparam logic [15:0] CUST_BASE       = 16'hfce0;
  localparam logic [15:0] CUST_LAST       = 16'hfcff;
  localparam logic [15:0] CFG1_ADDR       = 16'hfd00;
  localparam logic [15:0] CFG2_ADDR       = 16'hfd01;
  localparam logic [7:0]  ERASED_BYTE     = 8'hff;
  localparam int          CUST_BYTES      = 32;
  localparam int          CUST_AW         = 5;
  // Arbitrary signature values, not tied to any real part.
  localparam logic [7:0]  SIG_VAL0        = 8'h5a;
  localparam logic [7:0]  SIG_VAL1        = 8'ha5;
  localparam logic [7:0]  SIG_VAL2        = 8'h3c;
  // ==========================================================================
  // Serial programming commands.
  localparam logic [7:0]  CMD_PROG        = 8'h01;
  localparam logic [7:0]  CMD_VERIFY      = 8'h02;
  localparam logic [7:0]  CMD_PROG_LOCK1  = 8'h03;
  localparam logic [7:0]  CMD_PROG_LOCK2  = 8'h04;
  localparam int          FRAME_BITS      = 32;
  localparam int          REPLY_BITS      = 8;
  localparam int          FRAME_CW        = 6;
endpackage

// ---- rtl/ncsm_serial_port.sv ----
// Serial frame shifter for the two-pin programming link.
`timescale 1ns/10ps
module ncsm_serial_port (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        progEnable,
  input  wire logic        serClk,
  input  wire logic        serDataIn,
  output logic             serDataOut,
  output logic             serDataOe,
  output logic [31:0]      frameData,
  output logic             frameValid,
  input  wire logic [7:0]  replyData,
  input  wire logic        replyLoad
);
  logic [31:0] shift_q, shift_d;
  logic [5:0]  cnt_q, cnt_d;
  logic [7:0]  rep_q, rep_d;
  logic [3:0]  repCnt_q, repCnt_d;
  logic        clkPrev_q;
  logic        valid_q, valid_d;
  logic        rise;

  // ==========================================================================
  // Shifting on rising edges of the programmer's clock, sampled as a level.
  assign rise = serClk & ~clkPrev_q;

  always_comb begin
    shift_d  = shift_q;
    cnt_d    = cnt_q;
    rep_d    = rep_q;
    repCnt_d = repCnt_q;
    valid_d  = 1'b0;
    if (!progEnable) begin
      cnt_d    = '0;
      repCnt_d = '0;
    end else if (replyLoad) begin
      rep_d    = replyData;
      repCnt_d = 4'(ncsm_pkg::REPLY_BITS);
    end else if (rise && repCnt_q != '0) begin
      rep_d    = {rep_q[6:0], 1'b0};
      repCnt_d = repCnt_q - 4'h1;
    end else if (rise) begin
      shift_d = {shift_q[30:0], serDataIn};
      if (cnt_q == 6'(ncsm_pkg::FRAME_BITS - 1)) begin
        cnt_d   = '0;
        valid_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 6'h1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      shift_q   <= '0;
      cnt_q     <= '0;
      rep_q     <= '0;
      repCnt_q  <= '0;
      clkPrev_q <= 1'b0;
      valid_q   <= 1'b0;
    end else begin
      shift_q   <= shift_d;
      cnt_q     <= cnt_d;
      rep_q     <= rep_d;
      repCnt_q  <= repCnt_d;
      clkPrev_q <= serClk;
      valid_q   <= valid_d;
    end
  end

  // The device drives the data pin only while a reply is being shifted back.
  assign serDataOut = rep_q[7];
  assign serDataOe  = progEnable && repCnt_q != '0;
  assign frameData  = shift_q;
  assign frameValid = valid_q;
endmodule

// ---- rtl/nvm_config_security_map.sv ----
// Non-volatile extras: signature, customer area, configuration bytes and security.
//
// Contract
// - Serial commands and data over two pins.
// - Three signature bytes readable by code reads.
// - Customer area FCE0h-FCFFh returned by code reads.
// - No instruction fetch from customer area.
// - Customer area programmed in same serial session.
// - Configuration captured at power-up, software cannot change.
// - Configuration bytes readable by external reads.
// - External reads reach configuration information only.
// - Both locks unprogrammed: program and verify allowed.
// - Lock one programmed: only lock two programmable.
// - Both locks programmed: no verify, no program.
// - Verify stays enabled with lock one only.
`timescale 1ns/10ps
module nvm_config_security_map (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // Core side.
  input  wire logic [15:0] pointerRegister,
  input  wire logic        codeDataRead,
  input  wire logic        instrFetch,
  input  wire logic        externalDataRead,
  output logic [7:0]       readData,
  output logic             readHit,
  output logic             fetchFault,
  output logic [7:0]       systemConfigByteOne,
  output logic [7:0]       systemConfigByteTwo,
  // Programming link.
  input  wire logic        progEnable,
  input  wire logic        serClk,
  input  wire logic        serDataIn,
  output logic             serDataOut,
  output logic             serDataOe,
  output logic             programLockBit,
  output logic             verifyLockBit
);
  typedef enum logic [1:0] {NCSM_IDLE, NCSM_EXEC, NCSM_REPLY} ncsm_state_e;

  // Cells of the one-time memory are not reset; erased cells read as all ones.
  logic [7:0]  custMem [ncsm_pkg::CUST_BYTES] = '{default: ncsm_pkg::ERASED_BYTE};
  logic [7:0]  cfg1Nv_q = ncsm_pkg::ERASED_BYTE;
  logic [7:0]  cfg1Nv_d;
  logic [7:0]  cfg2Nv_q = ncsm_pkg::ERASED_BYTE;
  logic [7:0]  cfg2Nv_d;
  logic        lock1_q = 1'b1;
  logic        lock1_d;
  logic        lock2_q = 1'b1;
  logic        lock2_d;
  logic        progAllowed;
  logic        verifyAllowed;
  logic        lock1Allowed;
  logic        lock2Allowed;
  logic [7:0]  cfg1Live_q;
  logic [7:0]  cfg1Live_d;
  logic [7:0]  cfg2Live_q;
  logic [7:0]  cfg2Live_d;
  logic        captured_q;
  logic        captured_d;
  logic [7:0]  rd_q;
  logic [7:0]  rd_d;
  logic        hit_q;
  logic        hit_d;
  logic        fault_q;
  logic        fault_d;
  ncsm_state_e state_q;
  ncsm_state_e state_d;
  logic [31:0] frame_q;
  logic [31:0] frame_d;
  logic [7:0]  reply_q;
  logic [7:0]  reply_d;
  logic        replyLoad;
  logic [31:0] frameData;
  logic        frameValid;
  logic        custWr;
  logic [7:0]  custWrData;
  logic [7:0]  custRdProg;
  logic [7:0]  custRdCore;
  logic [ncsm_pkg::CUST_AW-1:0] custIdx;
  logic [ncsm_pkg::CUST_AW-1:0] ptrIdx;
  logic [7:0]  cmd;
  logic [15:0] addr;
  logic [7:0]  wdata;

  function automatic logic inCust(input logic [15:0] a);
    inCust = a >= ncsm_pkg::CUST_BASE && a <= ncsm_pkg::CUST_LAST;
  endfunction

  // Reads the programmable map as the programmer would see it.
  function automatic logic [7:0] mapRead(input logic [15:0] a, input logic [7:0] cv);
    if (a == ncsm_pkg::SIG_ADDR0)      mapRead = ncsm_pkg::SIG_VAL0;
    else if (a == ncsm_pkg::SIG_ADDR1) mapRead = ncsm_pkg::SIG_VAL1;
    else if (a == ncsm_pkg::SIG_ADDR2) mapRead = ncsm_pkg::SIG_VAL2;
    else if (inCust(a))                mapRead = cv;
    else                               mapRead = ncsm_pkg::ERASED_BYTE;
  endfunction

  function automatic logic isCfg(input logic [15:0] a);
    isCfg = a == ncsm_pkg::CFG1_ADDR || a == ncsm_pkg::CFG2_ADDR;
  endfunction

  // Configuration byte behind an address; only the two configuration addresses answer.
  function automatic logic [7:0] cfgRead(input logic [15:0] a,
                                         input logic [7:0]  c1,
                                         input logic [7:0]  c2);
    if (a == ncsm_pkg::CFG1_ADDR)      cfgRead = c1;
    else if (a == ncsm_pkg::CFG2_ADDR) cfgRead = c2;
    else                               cfgRead = ncsm_pkg::ERASED_BYTE;
  endfunction

  // One-time cells: programming can only clear bits, never set them again.
  function automatic logic [7:0] otpProg(input logic [7:0] old, input logic [7:0] d);
    otpProg = old & d;
  endfunction

  // ==========================================================================
  // Serial link.
  ncsm_serial_port u_port (
    .sys_clk    (sys_clk),
    .srst       (srst),
    .progEnable (progEnable),
    .serClk     (serClk),
    .serDataIn  (serDataIn),
    .serDataOut (serDataOut),
    .serDataOe  (serDataOe),
    .frameData  (frameData),
    .frameValid (frameValid),
    .replyData  (reply_q),
    .replyLoad  (replyLoad)
  );

  assign cmd   = frame_q[31:24];
  assign addr  = frame_q[23:8];
  assign wdata = frame_q[7:0];

  assign custIdx    = addr[ncsm_pkg::CUST_AW-1:0];
  assign ptrIdx     = pointerRegister[ncsm_pkg::CUST_AW-1:0];
  assign custRdProg = custMem[custIdx];
  assign custRdCore = custMem[ptrIdx];
  assign custWrData = otpProg(custRdProg, wdata);

  // ==========================================================================
  // Security decode.
  // Lock one alone stops programming; verify only goes once both locks are set.
  assign progAllowed   = lock1_q;
  assign verifyAllowed = lock2_q;
  // Lock two only follows lock one, so the unsupported pair can never arise.
  assign lock2Allowed  = !lock1_q;
  assign lock1Allowed  = lock2_q;

  // ==========================================================================
  // Command execution with security gating.
  always_comb begin
    state_d   = state_q;
    frame_d   = frame_q;
    reply_d   = reply_q;
    cfg1Nv_d  = cfg1Nv_q;
    cfg2Nv_d  = cfg2Nv_q;
    lock1_d   = lock1_q;
    lock2_d   = lock2_q;
    custWr    = 1'b0;
    replyLoad = 1'b0;
    case (state_q)
      NCSM_IDLE: begin
        if (frameValid) begin
          frame_d = frameData;
          state_d = NCSM_EXEC;
        end
      end
      NCSM_EXEC: begin
        state_d = NCSM_IDLE;
        case (cmd)
          ncsm_pkg::CMD_PROG: begin
            if (progAllowed) begin
              if (inCust(addr)) begin
                custWr = 1'b1;
              end else if (addr == ncsm_pkg::CFG1_ADDR) begin
                cfg1Nv_d = otpProg(cfg1Nv_q, wdata);
              end else if (addr == ncsm_pkg::CFG2_ADDR) begin
                cfg2Nv_d = otpProg(cfg2Nv_q, wdata);
              end
            end
          end
          ncsm_pkg::CMD_VERIFY: begin
            if (!verifyAllowed) begin
              reply_d = ncsm_pkg::ERASED_BYTE;
            end else if (isCfg(addr)) begin
              reply_d = cfgRead(addr, cfg1Nv_q, cfg2Nv_q);
            end else begin
              reply_d = mapRead(addr, custRdProg);
            end
            state_d = NCSM_REPLY;
          end
          ncsm_pkg::CMD_PROG_LOCK1: begin
            if (lock1Allowed) begin
              lock1_d = 1'b0;
            end
          end
          ncsm_pkg::CMD_PROG_LOCK2: begin
            if (lock2Allowed) begin
              lock2_d = 1'b0;
            end
          end
          default: ;
        endcase
      end
      NCSM_REPLY: begin
        replyLoad = 1'b1;
        state_d   = NCSM_IDLE;
      end
      default: state_d = NCSM_IDLE;
    endcase
    if (!progEnable) state_d = NCSM_IDLE;
  end

  // The write strobe only comes out of the command stage, so a blocked program never lands.
  always_ff @(posedge sys_clk) begin
    if (custWr) begin
      custMem[custIdx] <= custWrData;
    end
  end

  // ==========================================================================
  // Power-up capture.
  // The live copy is taken once per reset, so later programming of the cells
  // only shows after the next power-up.
  always_comb begin
    captured_d = 1'b1;
    cfg1Live_d = cfg1Live_q;
    cfg2Live_d = cfg2Live_q;
    if (!captured_q) begin
      cfg1Live_d = cfg1Nv_q;
      cfg2Live_d = cfg2Nv_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      captured_q <= 1'b0;
      cfg1Live_q <= ncsm_pkg::ERASED_BYTE;
      cfg2Live_q <= ncsm_pkg::ERASED_BYTE;
    end else begin
      captured_q <= captured_d;
      cfg1Live_q <= cfg1Live_d;
      cfg2Live_q <= cfg2Live_d;
    end
  end

  // ==========================================================================
  // Core reads.
  always_comb begin
    rd_d    = rd_q;
    hit_d   = 1'b0;
    fault_d = instrFetch && inCust(pointerRegister);
    if (codeDataRead) begin
      rd_d  = mapRead(pointerRegister, custRdCore);
      hit_d = 1'b1;
    end else if (externalDataRead) begin
      hit_d = 1'b1;
      // Anything outside the two configuration bytes has nothing behind it.
      rd_d  = cfgRead(pointerRegister, cfg1Nv_q, cfg2Nv_q);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rd_q    <= '0;
      hit_q   <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      rd_q    <= rd_d;
      hit_q   <= hit_d;
      fault_q <= fault_d;
    end
  end

  // ==========================================================================
  // Command stage registers.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_q <= NCSM_IDLE;
      frame_q <= '0;
      reply_q <= '0;
    end else begin
      state_q <= state_d;
      frame_q <= frame_d;
      reply_q <= reply_d;
    end
  end

  // ==========================================================================
  // Non-volatile cells: no reset, they keep their content across it.
  always_ff @(posedge sys_clk) begin
    cfg1Nv_q <= cfg1Nv_d;
    cfg2Nv_q <= cfg2Nv_d;
    lock1_q  <= lock1_d;
    lock2_q  <= lock2_d;
  end

  assign readData            = rd_q;
  assign readHit             = hit_q;
  assign fetchFault          = fault_q;
  assign systemConfigByteOne = cfg1Live_q;
  assign systemConfigByteTwo = cfg2Live_q;
  assign programLockBit      = lock1_q;
  assign verifyLockBit       = lock2_q;
endmodule

// ---- sim/ncsm_properties.sv ----
// Checker for core reads, fetch faults, configuration and locks.
`timescale 1ns/10ps
module ncsm_checker (
  input wire logic        sys_clk,
  input wire logic        srst,
  input wire logic [15:0] pointerRegister,
  input wire logic        codeDataRead,
  input wire logic        instrFetch,
  input wire logic        externalDataRead,
  input wire logic [7:0]  readData,
  input wire logic        readHit,
  input wire logic        fetchFault,
  input wire logic [7:0]  systemConfigByteOne,
  input wire logic [7:0]  systemConfigByteTwo,
  input wire logic        programLockBit,
  input wire logic        verifyLockBit
);
  // ==========================================================================
  // Properties.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  sequence extOnly;
    externalDataRead && !codeDataRead;
  endsequence
  // Capture lands on the first edge after release, so wait past it.
  sequence settled;
    !srst [*5];
  endsequence
  read_answer_a: assert property ((codeDataRead || externalDataRead) |=> readHit)
    else $error("read not answered");
  hit_cause_a: assert property (!(codeDataRead || externalDataRead) |=> !readHit)
    else $error("readHit without request");
  sig_value_a: assert property (codeDataRead && pointerRegister == ncsm_pkg::SIG_ADDR1
    |=> readData == ncsm_pkg::SIG_VAL1) else $error("bad signature");
  ext_outside_a: assert property (extOnly and pointerRegister != ncsm_pkg::CFG1_ADDR
    && pointerRegister != ncsm_pkg::CFG2_ADDR |=> readData == ncsm_pkg::ERASED_BYTE)
    else $error("external read leaked");
  ext_config_a: assert property (extOnly and pointerRegister == ncsm_pkg::CFG1_ADDR
    |=> readData == systemConfigByteOne) else $error("config read wrong");
  cfg_frozen_a: assert property (settled |-> $stable(systemConfigByteOne)
    && $stable(systemConfigByteTwo)) else $error("config changed");
  fetch_fault_a: assert property (instrFetch && pointerRegister >= ncsm_pkg::CUST_BASE
    && pointerRegister <= ncsm_pkg::CUST_LAST |=> fetchFault) else $error("no fault");
  fault_cause_a: assert property (fetchFault |-> $past(instrFetch))
    else $error("fault without fetch");
  lock_combo_a: assert property (!(programLockBit && !verifyLockBit))
    else $error("lock two set alone");
  lock_otp_a: assert property (!$rose(programLockBit) && !$rose(verifyLockBit))
    else $error("lock cell erased");
endmodule
bind nvm_config_security_map ncsm_checker u_ncsm_checker (.sys_clk, .srst, .pointerRegister,
  .codeDataRead, .instrFetch, .externalDataRead, .readData, .readHit, .fetchFault,
  .systemConfigByteOne, .systemConfigByteTwo, .programLockBit, .verifyLockBit);

// ---- sim/ncsm_prog_model.sv ----
// Behavioural model of the external programming system on the two-pin link.
`timescale 1ns/10ps
module ncsm_prog_model (
  input  wire logic sys_clk,
  input  wire logic serDataOut,
  input  wire logic serDataOe,
  output logic      progEnable,
  output logic      serClk,
  output logic      serDataIn
);
  initial begin
    progEnable = 1'b0;
    serClk     = 1'b0;
    serDataIn  = 1'b0;
  end
  // Each phase spans two system clocks so the device sees every edge.
  task automatic pulse();
    repeat (2) @(posedge sys_clk);
    serClk <= 1'b1;
    repeat (2) @(posedge sys_clk);
    serClk <= 1'b0;
  endtask
  task automatic frame(input logic [31:0] f, output logic [7:0] r, output logic oe);
    r  = 8'hff;
    oe = 1'b0;
    @(posedge sys_clk);
    progEnable <= 1'b1;
    for (int i = 31; i >= 0; i--) begin
      @(posedge sys_clk);
      serDataIn <= f[i];
      pulse();
    end
    repeat (6) @(posedge sys_clk);
    if (f[31:24] == ncsm_pkg::CMD_VERIFY) begin
      #1;
      oe = serDataOe;
      for (int i = 7; i >= 0; i--) begin
        #1;
        // A released line floats; showing the inverse catches an early release.
        r[i] = serDataOe ? serDataOut : ~serDataOut;
        pulse();
      end
    end
  endtask
endmodule

// ---- sim/tb_nvm_config_security_map.sv ----
// Self-checking testbench for the configuration loader.
`timescale 1ns/10ps
module tb_nvm_config_security_map;
  logic sys_clk, srst, codeDataRead, instrFetch, externalDataRead, readHit, fetchFault;
  logic progEnable, serClk, serDataIn, serDataOut, serDataOe, programLockBit, verifyLockBit;
  logic [15:0] pointerRegister;
  logic [7:0]  readData, systemConfigByteOne, systemConfigByteTwo, reply;
  logic        oe;
  int          nErrors, numChecks, cyc;
  nvm_config_security_map u_nvm_config_security_map (.sys_clk, .srst, .pointerRegister,
    .codeDataRead, .instrFetch, .externalDataRead, .readData, .readHit, .fetchFault,
    .systemConfigByteOne, .systemConfigByteTwo, .progEnable, .serClk, .serDataIn,
    .serDataOut, .serDataOe, .programLockBit, .verifyLockBit);
  ncsm_prog_model u_ncsm_prog_model (.sys_clk, .serDataOut, .serDataOe, .progEnable,
    .serClk, .serDataIn);
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    numChecks++;
    if (s !== e) begin
      nErrors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic test_done();
    if (nErrors == 0 && numChecks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Safety net against a hung handshake.
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      nErrors++;
      test_done();
    end
  end
  task automatic doReset();
    srst <= 1'b1;
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
  // Kind bits: 0 code read, 1 external read, 2 fetch.
  task automatic rd(input logic [2:0] k, input logic [15:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    pointerRegister  <= a;
    codeDataRead     <= k[0];
    externalDataRead <= k[1];
    instrFetch       <= k[2];
    @(posedge sys_clk);
    codeDataRead     <= 1'b0;
    externalDataRead <= 1'b0;
    instrFetch       <= 1'b0;
    #1;
    if (k[2]) begin
      chk({7'h00, fetchFault}, e);
    end else begin
      chk({7'h00, readHit}, 8'h01);
      chk(readData, e);
    end
  endtask
  task automatic prog(input logic [7:0] c, input logic [15:0] a, input logic [7:0] d);
    u_ncsm_prog_model.frame({c, a, d}, reply, oe);
  endtask
  task automatic ver(input logic [15:0] a, input logic [7:0] e);
    u_ncsm_prog_model.frame({ncsm_pkg::CMD_VERIFY, a, 8'h00}, reply, oe);
    chk({7'h00, oe}, 8'h01);
    chk(reply, e);
  endtask
  initial begin
    {srst, codeDataRead, instrFetch, externalDataRead} = 4'h8;
    pointerRegister = 16'h0000;
    {nErrors, numChecks, cyc} = '0;
    doReset();
    chk(systemConfigByteOne, 8'hff);
    chk(systemConfigByteTwo, 8'hff);
    rd(3'h1, ncsm_pkg::SIG_ADDR0, ncsm_pkg::SIG_VAL0);
    rd(3'h1, ncsm_pkg::SIG_ADDR1, ncsm_pkg::SIG_VAL1);
    rd(3'h1, ncsm_pkg::SIG_ADDR2, ncsm_pkg::SIG_VAL2);
    rd(3'h1, ncsm_pkg::CUST_LAST, 8'hff);
    rd(3'h2, ncsm_pkg::CFG1_ADDR, 8'hff);
    rd(3'h2, ncsm_pkg::SIG_ADDR0, 8'hff);
    rd(3'h3, ncsm_pkg::SIG_ADDR0, ncsm_pkg::SIG_VAL0);
    rd(3'h4, ncsm_pkg::CUST_BASE, 8'h01);
    rd(3'h4, 16'hfcdf, 8'h00);
    prog(ncsm_pkg::CMD_PROG, ncsm_pkg::CUST_BASE, 8'h12);
    prog(ncsm_pkg::CMD_PROG, ncsm_pkg::CUST_LAST, 8'h34);
    prog(ncsm_pkg::CMD_PROG, ncsm_pkg::CUST_BASE, 8'hf0);
    prog(ncsm_pkg::CMD_PROG, ncsm_pkg::CFG2_ADDR, 8'h7e);
    rd(3'h1, ncsm_pkg::CUST_BASE, 8'h10);
    rd(3'h1, ncsm_pkg::CUST_LAST, 8'h34);
    chk(systemConfigByteTwo, 8'hff);
    ver(ncsm_pkg::CUST_BASE, 8'h10);
    doReset();
    chk(systemConfigByteTwo, 8'h7e);
    rd(3'h2, ncsm_pkg::CFG2_ADDR, 8'h7e);
    prog(ncsm_pkg::CMD_PROG_LOCK2, 16'h0000, 8'h00);
    chk({7'h00, verifyLockBit}, 8'h01);
    prog(ncsm_pkg::CMD_PROG_LOCK1, 16'h0000, 8'h00);
    chk({7'h00, programLockBit}, 8'h00);
    prog(ncsm_pkg::CMD_PROG, 16'hfce1, 8'h00);
    rd(3'h1, 16'hfce1, 8'hff);
    ver(ncsm_pkg::CUST_BASE, 8'h10);
    ver(ncsm_pkg::CFG2_ADDR, 8'h7e);
    prog(ncsm_pkg::CMD_PROG_LOCK2, 16'h0000, 8'h00);
    chk({7'h00, verifyLockBit}, 8'h00);
    ver(ncsm_pkg::CUST_BASE, 8'hff);
    prog(ncsm_pkg::CMD_PROG, ncsm_pkg::CUST_LAST, 8'h00);
    rd(3'h1, ncsm_pkg::CUST_LAST, 8'h34);
    test_done();
  end
endmodule
